// ---- adcc_conversion_control.sv ----
/*
  Digital control of an 8-bit successive-approximation converter with its
  register file on AXI4-Lite, a sticky interrupt status with mask, and the
  special event trigger from compare unit two.
  Assumes a synchronous comparator answer and pin levels, an RC tick pulse
  from the internal oscillator, and an outside pin-configuration decode.
*/
// Overview of operation
// - A conversion lasts nine and a half bit periods from start to result.
// - Clock select 00, 01, 10 give 2, 8, 32 oscillator periods; 11 uses the RC tick.
// - The port view reads zero for every pin configured as analog input.
// - A selected pin set as output is converted from its driven digital level.
// - Sequencing does not depend on the channel field or the direction bits.
// - A special event trigger starts only in compare mode 1011 with the converter on.
// - An accepted trigger sets the go flag, starts a conversion and clears the timer.
// - With the converter off a trigger is ignored but still clears the timer.
// - On completion the result loads, the go flag clears and the done flag sets.
// - Channel codes 000 to 100 select channels 0 to 4.
// - Reset turns the converter off, aborts a conversion and resets the registers.
`timescale 1ns/100ps
module adcc_conversion_control (
  input wire logic aclk,                                    // System clock
  input wire logic aresetn,                                 // Sync reset, low
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_awaddr,     // Write address
  input wire logic s_axi_awvalid,                           // Write address valid
  output logic s_axi_awready,                               // Write address ready
  input wire logic [31:0] s_axi_wdata,                      // Write data
  input wire logic [3:0] s_axi_wstrb,                       // Write strobes
  input wire logic s_axi_wvalid,                            // Write data valid
  output logic s_axi_wready,                                // Write data ready
  output logic [1:0] s_axi_bresp,                           // Write response
  output logic s_axi_bvalid,                                // Write response valid
  input wire logic s_axi_bready,                            // Write response ready
  input wire logic [adcc_pkg::ADDR_W-1:0] s_axi_araddr,     // Read address
  input wire logic s_axi_arvalid,                           // Read address valid
  output logic s_axi_arready,                               // Read address ready
  output logic [31:0] s_axi_rdata,                          // Read data
  output logic [1:0] s_axi_rresp,                           // Read response
  output logic s_axi_rvalid,                                // Read data valid
  input wire logic s_axi_rready,                            // Read data ready
  input wire logic rc_tick,                                 // RC half-period pulse
  input wire logic cmp_above,                               // Input above trial code
  input wire logic [adcc_pkg::NUM_CHAN-1:0] pin_dir_input,  // Direction, 1 = input
  input wire logic [adcc_pkg::NUM_CHAN-1:0] pin_out_level,  // Driven pin levels
  input wire logic [7:0] port_pin_level,                    // Raw port levels
  input wire logic [7:0] analog_pin_mask,                   // 1 = analog pin
  input wire logic special_event_trig,                      // Compare unit pulse
  input wire logic [3:0] compare_mode_field,                // Compare unit mode
  output logic [7:0] dac_code,                              // Trial code
  output logic [2:0] input_channel_select,                  // Channel to mux
  output logic acquire,                                     // Hold cap tracks input
  output logic [adcc_pkg::PINCFG_W-1:0] pin_config_field,   // To pin decode
  output logic timer_clear,                                 // Clears 16-bit counter
  output logic irq                                          // Level interrupt
);
  import adcc_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_CONV} adcc_state_t;

  adcc_state_t state_r;
  adcc_ctrl_t ctrl_r;
  adcc_ctrl_t wd;
  logic [7:0] result_r;
  logic [PINCFG_W-1:0] pincfg_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic [4:0] div_cnt_r;
  logic [4:0] half_cnt_r;
  logic [2:0] bit_idx_r;
  logic [7:0] sar_r;
  logic [7:0] sar_nxt;
  logic [4:0] half_div;
  logic [4:0] half_nxt;
  logic wr_fire;
  logic wr_ctrl;
  logic half_tick;
  logic decide;
  logic cmp_bit;
  logic sw_go;
  logic trig_ok;
  logic start;
  logic done;
  logic [7:0] rd_mux;
  logic rd_ok;
  logic [1:0] stat_nxt;

  // Register index from a byte address; null index for addresses at or above 0x400
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = (a[ADDR_W-1:10] == '0) ? a[9:2] : 8'hFF;
  endfunction

  // Register exists at this index
  function automatic logic reg_mapped(input logic [7:0] i);
    reg_mapped = (i == IDX_RESULT) || (i == IDX_CTRL) || (i == IDX_PINCFG) ||
                 (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK) || (i == IDX_PORT_VIEW);
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  // Address and data taken in either order; the write lands once both are in
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wd = adcc_ctrl_t'(wdata_r[7:0]);
  assign wr_ctrl = wr_fire && wstrb0_r && (reg_index(awaddr_r) == IDX_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_mapped(reg_index(awaddr_r)) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  // Read data mux; narrow registers sit in the low bits
  always_comb begin
    rd_mux = 8'h00;
    rd_ok = reg_mapped(reg_index(s_axi_araddr));
    case (reg_index(s_axi_araddr))
      IDX_RESULT: rd_mux = result_r;
      IDX_CTRL: rd_mux = {ctrl_r.clk_sel, ctrl_r.chan, ctrl_r.go, 1'b0, ctrl_r.on};
      IDX_PINCFG: rd_mux = {5'h00, pincfg_r};
      IDX_IRQ_STATUS: rd_mux = {6'h00, irq_stat_r};
      IDX_IRQ_MASK: rd_mux = {6'h00, irq_mask_r};
      IDX_PORT_VIEW: rd_mux = port_pin_level & ~analog_pin_mask;
      default: rd_mux = 8'h00;
    endcase
  end

  // One-cycle read answer, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_mux};
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Start qualification
  // ---------------------------------------------------------------
  // Go needs the converter already on, so on and go in one write only turn it on and start nothing
  assign sw_go = wr_ctrl && wd.go && wd.on && ctrl_r.on && (state_r == ST_IDLE);
  assign trig_ok = special_event_trig && (compare_mode_field == TRIG_MODE) &&
                   ctrl_r.on && (state_r == ST_IDLE);
  assign start = sw_go || trig_ok;

  // ---------------------------------------------------------------
  // Bit period timebase
  // ---------------------------------------------------------------
  // Half bit period, so the closing half period needs no second counter
  always_comb begin
    case (ctrl_r.clk_sel)
      CLK_OSC2: half_div = HALF_DIV_0;
      CLK_OSC8: half_div = HALF_DIV_1;
      CLK_OSC32: half_div = HALF_DIV_2;
      default: half_div = HALF_DIV_0;
    endcase
  end

  assign half_tick = (state_r == ST_CONV) &&
                     ((ctrl_r.clk_sel == CLK_RC) ? rc_tick : (div_cnt_r == half_div - 5'h01));

  // Divider restarts at each start so the first period is whole
  always_ff @(posedge aclk) begin
    if (!aresetn || start || half_tick || state_r == ST_IDLE) begin
      div_cnt_r <= 5'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Successive approximation sequencer
  // ---------------------------------------------------------------
  // Same sequence for any channel or direction; only the compare source moves
  assign half_nxt = half_cnt_r + 5'h01;
  assign decide = half_tick && (half_nxt >= FIRST_DECIDE) && !half_nxt[0];
  assign done = half_tick && (half_nxt == CONV_HALF_TADS);
  assign cmp_bit = (ctrl_r.chan < 3'(NUM_CHAN) && !pin_dir_input[ctrl_r.chan]) ?
                   pin_out_level[ctrl_r.chan] : cmp_above;

  // Keep the trial bit when the input is above, then try the next one down
  always_comb begin
    sar_nxt = sar_r;
    if (decide) begin
      sar_nxt[bit_idx_r] = cmp_bit;
      if (bit_idx_r != 3'h0) begin
        sar_nxt[bit_idx_r - 3'h1] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      half_cnt_r <= 5'h00;
      bit_idx_r <= 3'h7;
      sar_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_CONV;
            half_cnt_r <= 5'h00;
            bit_idx_r <= 3'h7;
            sar_r <= 8'h80;
          end
        end
        ST_CONV: begin
          if (!ctrl_r.on || done) begin
            state_r <= ST_IDLE;
          end else if (half_tick) begin
            half_cnt_r <= half_nxt;
          end
          if (decide) begin
            bit_idx_r <= bit_idx_r - 3'h1;
          end
          sar_r <= sar_nxt;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control, configuration and result registers
  // ---------------------------------------------------------------
  // Go is set by start, cleared by completion or by switching off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= adcc_ctrl_t'(CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_r.clk_sel <= wd.clk_sel;
        ctrl_r.chan <= wd.chan;
        ctrl_r.on <= wd.on;
      end
      if (start) begin
        ctrl_r.go <= 1'b1;
      end else if (done || (wr_ctrl && !wd.on)) begin
        ctrl_r.go <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pincfg_r <= PINCFG_RST[PINCFG_W-1:0];
    end else if (wr_fire && wstrb0_r && reg_index(awaddr_r) == IDX_PINCFG) begin
      pincfg_r <= wdata_r[PINCFG_W-1:0];
    end
  end

  // Completion wins over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= RESULT_RST;
    end else if (done) begin
      result_r <= sar_nxt;
    end else if (wr_fire && wstrb0_r && reg_index(awaddr_r) == IDX_RESULT) begin
      result_r <= wdata_r[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  // Write one to clear; a new event in the same cycle stays set
  always_comb begin
    stat_nxt = irq_stat_r;
    if (wr_fire && wstrb0_r && reg_index(awaddr_r) == IDX_IRQ_STATUS) begin
      stat_nxt = irq_stat_r & ~wdata_r[1:0];
    end
    if (done) begin
      stat_nxt[IRQ_DONE_BIT] = 1'b1;
    end
    if (special_event_trig && !ctrl_r.on) begin
      stat_nxt[IRQ_IGN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= stat_nxt;
      irq <= |(irq_stat_r & irq_mask_r);
      if (wr_fire && wstrb0_r && reg_index(awaddr_r) == IDX_IRQ_MASK) begin
        irq_mask_r <= wdata_r[1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the analog side and the timer
  // ---------------------------------------------------------------
  // Timer clear follows every trigger, accepted or not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_clear <= 1'b0;
      dac_code <= 8'h00;
      input_channel_select <= 3'h0;
      acquire <= 1'b0;
      pin_config_field <= PINCFG_RST[PINCFG_W-1:0];
    end else begin
      timer_clear <= special_event_trig;
      dac_code <= sar_nxt;
      input_channel_select <= ctrl_r.chan;
      acquire <= ctrl_r.on && (state_r == ST_IDLE) && !start;
      pin_config_field <= pincfg_r;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [9:0] conv_cyc_r;
  logic [1:0] sel_at_start_r;
  logic rd_port_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      conv_cyc_r <= 10'h000;
      // A software start writes the select in the same cycle, so take the new value
      sel_at_start_r <= start ? (wr_ctrl ? wd.clk_sel : ctrl_r.clk_sel) : 2'h0;
    end else if (state_r == ST_CONV) begin
      conv_cyc_r <= conv_cyc_r + 10'h001;
    end
    rd_port_r <= s_axi_arvalid && s_axi_arready &&
                 reg_index(s_axi_araddr) == IDX_PORT_VIEW;
  end

  chk_conv_length: assert property (@(posedge aclk) disable iff (!aresetn)
    done && sel_at_start_r == CLK_OSC8 && ctrl_r.clk_sel == CLK_OSC8 |->
      conv_cyc_r == 10'h04B) else $error("conversion length wrong");
  chk_done_effects: assert property (@(posedge aclk) disable iff (!aresetn)
    done |=> !ctrl_r.go && irq_stat_r[IRQ_DONE_BIT] && state_r == ST_IDLE)
    else $error("completion effects missing");
  chk_trig_accept: assert property (@(posedge aclk) disable iff (!aresetn)
    special_event_trig && compare_mode_field == TRIG_MODE && ctrl_r.on && !ctrl_r.go
      |=> ctrl_r.go && state_r == ST_CONV && timer_clear)
    else $error("trigger not accepted");
  chk_trig_wrong_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_IDLE && special_event_trig && compare_mode_field != TRIG_MODE && !sw_go
      |=> state_r == ST_IDLE) else $error("trigger started in wrong mode");
  chk_trig_off: assert property (@(posedge aclk) disable iff (!aresetn)
    special_event_trig && !ctrl_r.on |=> timer_clear && !ctrl_r.go)
    else $error("trigger with converter off misbehaved");
  chk_no_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == ST_CONV && ctrl_r.on && !done |=> half_cnt_r >= $past(half_cnt_r))
    else $error("conversion restarted");
  chk_port_analog_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_port_r |-> (s_axi_rdata[7:0] & $past(analog_pin_mask)) == 8'h00)
    else $error("analog pin read as one");
  chk_digital_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    decide && ctrl_r.chan < 3'(NUM_CHAN) && !pin_dir_input[ctrl_r.chan] |=>
      sar_r[$past(bit_idx_r)] == $past(pin_out_level[ctrl_r.chan]))
    else $error("driven pin level not converted");
  chk_reset_off: assert property (@(posedge aclk)
    !aresetn |=> ctrl_r == adcc_ctrl_t'(CTRL_RST) && state_r == ST_IDLE)
    else $error("reset did not turn converter off");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq == |($past(irq_stat_r) & $past(irq_mask_r)))
    else $error("interrupt level wrong");

  cov_sw_conv: cover property (@(posedge aclk) disable iff (!aresetn) sw_go ##[1:300] done);
  cov_trig_conv: cover property (@(posedge aclk) disable iff (!aresetn) trig_ok ##[1:300] done);
  cov_trig_off: cover property (@(posedge aclk) disable iff (!aresetn)
    special_event_trig && !ctrl_r.on);

endmodule

// ---- adcc_far_model.sv ----
/*
  Analog side seen by the converter: a fixed input voltage and a comparator.
  Assumes the trial code settles before each decision cycle.
*/
`timescale 1ns/100ps
module adcc_far_model (
  input wire logic [7:0] dac_code, // Trial code
  input wire logic [7:0] vin,      // Input level as code
  output logic cmp_above           // Input at or above trial
);
  // Ideal comparator; no noise, so results are exact
  assign cmp_above = (vin >= dac_code);
endmodule

// ---- adcc_pkg.sv ----
/*
  Shared constants and types of the converter control block: register
  indices, field layouts, reset values, timing counts and bus answers.
  Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock that also
  stands in for the oscillator period.
*/
package adcc_pkg;

  // ---------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_RESULT = 8'h1E;
  localparam logic [7:0] IDX_CTRL = 8'h1F;
  localparam logic [7:0] IDX_PINCFG = 8'h9F;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hA1;
  localparam logic [7:0] IDX_PORT_VIEW = 8'hA2;

  // ---------------------------------------------------------------
  // Reset values and field layouts
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PINCFG_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_IGN_BIT = 1;
  localparam int PINCFG_W = 3;
  localparam int NUM_CHAN = 5;

  typedef struct packed {
    logic [1:0] clk_sel;   // conv_clock_select
    logic [2:0] chan;      // input_channel_select
    logic go;              // conversion go flag
    logic unused;          // reads as zero
    logic on;              // converter_on
  } adcc_ctrl_t;

  typedef enum logic [1:0] {
    CLK_OSC2 = 2'h0,
    CLK_OSC8 = 2'h1,
    CLK_OSC32 = 2'h2,
    CLK_RC = 2'h3
  } adcc_clksel_t;

  // ---------------------------------------------------------------
  // Timing: oscillator periods per bit period, counted in half periods
  // ---------------------------------------------------------------
  localparam int TOSC_PER_TAD_0 = 2;
  localparam int TOSC_PER_TAD_1 = 8;
  localparam int TOSC_PER_TAD_2 = 32;
  localparam logic [4:0] HALF_DIV_0 = 5'(TOSC_PER_TAD_0 / 2);
  localparam logic [4:0] HALF_DIV_1 = 5'(TOSC_PER_TAD_1 / 2);
  localparam logic [4:0] HALF_DIV_2 = 5'(TOSC_PER_TAD_2 / 2);
  localparam logic [4:0] CONV_HALF_TADS = 5'h13;   // 9.5 bit periods
  localparam logic [4:0] FIRST_DECIDE = 5'h04;
  localparam logic [3:0] TRIG_MODE = 4'hB;

  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- tb_top.sv ----
/*
  Register-level bench of the converter control over AXI4-Lite.
  Assumes bready and rready may stay high and the RC tick toggles every clock.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import adcc_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, trig = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [4:0] dir = 5'h1D, lvl = 5'h02;
  logic [3:0] mode = 4'hB;
  logic [7:0] pl = 8'hFF, am = 8'h0F, dac, d;
  logic [1:0] r, br;
  logic awr, wr_, bv, arr, rv, cmp, tclr, irq, acq;
  logic [2:0] ch, pc;
  logic rc = 0;
  logic [31:0] rdat;
  int n_errors = 0, n_tests = 0, cyc = 0, n;
  int h[3] = '{1, 4, 16};
  adcc_conversion_control u_adcc_conversion_control (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(r), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1), .rc_tick(rc), .cmp_above(cmp), .pin_dir_input(dir),
    .pin_out_level(lvl), .port_pin_level(pl), .analog_pin_mask(am),
    .special_event_trig(trig), .compare_mode_field(mode), .dac_code(dac),
    .input_channel_select(ch), .acquire(acq), .pin_config_field(pc), .timer_clear(tclr),
    .irq(irq));
  adcc_far_model u_adcc_far_model (.dac_code(dac), .vin(8'h5A), .cmp_above(cmp));
  // ----------------------------------------------------------
  // Clock, timeout and bus tasks
  // ----------------------------------------------------------
  always #4 aclk = ~aclk;
  // RC tick on every other clock, so a half bit period is two clocks
  always @(posedge aclk) rc <= ~rc;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin n_errors++; test_done(); end
  end
  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    awa <= {2'b00, i, 2'b00}; wd <= {24'h0, v}; awv <= 1; wv <= 1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 0;
      if (wv && wr_) wv <= 0;
    end while (bv !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    ara <= {2'b00, i, 2'b00}; arv <= 1;
    do begin @(posedge aclk); if (arv && arr) arv <= 0; end while (rv !== 1'b1);
    v = rdat[7:0];
  endtask
  // Counts clocks to the interrupt as seen at the edge, one past its register
  task automatic wirq(input bit pulse);
    n = 0;
    do begin
      @(posedge aclk); n++;
      if (pulse) trig <= (n == 10);
      if (pulse && n == 12) `CHK(tclr, 1'b1)
    end while (irq !== 1'b1 && n < 2000);
  endtask
  // One-clock pulse; the timer clear is read at the edge after it is launched
  task automatic pulse_trig();
    trig <= 1; @(posedge aclk); trig <= 0;
    @(posedge aclk); `CHK(tclr, 1'b1)
  endtask
  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(IDX_CTRL, d); `CHK(d, CTRL_RST)
    rd(IDX_PINCFG, d); `CHK(d, PINCFG_RST)
    rd(8'h50, d); `CHK(r, RESP_SLVERR)
    wr(8'h50, 8'h00); `CHK(br, RESP_SLVERR)
    rd(IDX_PORT_VIEW, d); `CHK(d, 8'hF0)
    // Nonzero pin setting so the later reset can be seen to clear it
    wr(IDX_PINCFG, 8'h05); rd(IDX_PINCFG, d); `CHK(d, 8'h05)
    `CHK(pc, 3'h5)
    $display("test reset done");
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CTRL, 8'h01); // on first, go later
    // Select 00..11, channel follows select; channel 1 drives a one
    // Select 11 stands for a sleep conversion on the RC tick
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CTRL, {s[1:0], s[2:0], 3'b101});
      wirq(s == 1);
      // Start edge and sampling edge add one count; RC phase can take one away
      if (s < 3) `CHK(n, 19 * h[s] + 1)
      else `CHK(n == 38 || n == 39, 1'b1)
      `CHK(ch, s[2:0])
      rd(IDX_RESULT, d); `CHK(d, (s == 1) ? 8'hFF : 8'h5A)
      rd(IDX_CTRL, d); `CHK(d, {s[1:0], s[2:0], 3'b001})
      wr(IDX_IRQ_STATUS, 8'h01);
      repeat (70) @(posedge aclk);
      `CHK(irq, 1'b0)
      `CHK(acq, 1'b1)
    end
    $display("test convert done");
    wr(IDX_CTRL, 8'h00);
    pulse_trig();
    rd(IDX_IRQ_STATUS, d); `CHK(d, 8'h02)
    wr(IDX_IRQ_STATUS, 8'h02);
    wr(IDX_CTRL, 8'h01);
    pulse_trig();
    rd(IDX_CTRL, d); `CHK(d, 8'h05)
    `CHK(acq, 1'b0)
    wirq(0);
    rd(IDX_RESULT, d); `CHK(d, 8'h5A)
    wr(IDX_IRQ_STATUS, 8'h01);
    mode <= 4'hA;
    pulse_trig();
    rd(IDX_CTRL, d); `CHK(d, 8'h01)
    $display("test trigger done");
    wr(IDX_CTRL, 8'h85);
    aresetn <= 0; @(posedge aclk); aresetn <= 1;
    rd(IDX_CTRL, d); `CHK(d, CTRL_RST)
    rd(IDX_PINCFG, d); `CHK(d, PINCFG_RST)
    rd(IDX_RESULT, d); `CHK(d, RESULT_RST)
    `CHK(pc, PINCFG_RST)
    $display("test abort done");
    test_done();
  end
endmodule
